// File: fews_pkg.sv
// package: flash erase/write sequencer constants and types
package fews_pkg;
  // ===========================================
  // clock source select
  localparam logic [1:0] SRC_AUX = 2'h0;
  localparam logic [1:0] SRC_SUB = 2'h1;
  localparam logic [1:0] SRC_MAIN = 2'h2;
  localparam int DIV_W = 6;
  // ===========================================
  // key byte
  localparam logic [7:0] KEY_WRITE = 8'ha5;
  localparam logic [7:0] KEY_READ = 8'h96;
  // ===========================================
  // flash geometry (word address, 16-bit words)
  localparam int ADDR_W = 15;
  localparam int MAIN_WORDS = 2048;
  localparam int INFO_WORDS = 128;
  localparam int SEG_MAIN_W = 8;
  localparam int SEG_INFO_W = 6;
  localparam int BLOCK_W = 5;
  localparam logic [ADDR_W-1:0] INFO_BASE = 15'h0800;
  localparam logic [ADDR_W-1:0] MAIN_BASE = 15'h7800;
  localparam logic [15:0] ERASED_WORD = 16'hffff;
  localparam logic [15:0] SELF_JUMP = 16'h3fff;
  // ===========================================
  // timing in generator cycles
  localparam logic [15:0] T_WORD = 16'd35;
  localparam logic [15:0] T_WORD_HV = 16'd32;
  localparam logic [15:0] T_BLOCK_FIRST = 16'd30;
  localparam logic [15:0] T_BLOCK_NEXT = 16'd21;
  localparam logic [15:0] T_BLOCK_END = 16'd6;
  localparam logic [15:0] T_SEG_ERASE = 16'd4819;
  localparam logic [15:0] T_MASS_ERASE = 16'd5297;
  // ===========================================
  // control bits
  typedef struct packed {
    logic emergency_stop_bit;
    logic block_program_mode;
    logic program_enable;
    logic mass_wipe_select;
    logic segment_wipe;
  } fews_ctrl_t;
  typedef struct packed {
    logic [1:0] src_sel;
    logic [DIV_W-1:0] ftg_divider_field;
  } fews_clk_t;
  typedef struct packed {
    logic req;
    logic wr;
    logic fetch;
    logic from_ram;
    logic [ADDR_W-1:0] addr;
    logic [15:0] wdata;
  } fews_acc_t;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ERASE = 3'b001,
    ST_WORD = 3'b010,
    ST_BLK_WAIT = 3'b011,
    ST_BLK_PROG = 3'b100,
    ST_BLK_END = 3'b101
  } fews_state_t;
endpackage

// File: fews_tick_div.sv
// module: timing generator clock divider producing a one-cycle tick
`timescale 1ns/1ns
module fews_tick_div (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic run_i,
  input wire logic src_en_i,
  input wire logic [fews_pkg::DIV_W-1:0] div_i,
  output logic tick_o
);
  logic [fews_pkg::DIV_W-1:0] cnt_q;
  // divide selected source by div+1; runs only during an operation
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_q <= '0;
      tick_o <= 1'b0;
    end else if (!run_i) begin
      cnt_q <= '0;
      tick_o <= 1'b0;
    end else if (src_en_i) begin
      tick_o <= (cnt_q == div_i);
      cnt_q <= (cnt_q == div_i) ? '0 : cnt_q + 1'b1;
    end else begin
      tick_o <= 1'b0;
    end
  end
endmodule

// File: fews_top.sv
// module: flash erase/write sequencer with its flash array
// How it works
// - source aux, sub-main or main, then divided
// - erased reads one, writes only clear bits
// - erase always covers whole segments
// - mass/segment bits pick segment, main, all
// - dummy write in range starts erase
// - busy during erase; end clears busy, modes
// - erase duration fixed, size independent
// - out-of-range dummy write silently ignored
// - interrupts masked while any cycle runs
// - erase from flash stalls the cpu
// - flash access during ram erase flags violation
// - block/program bits pick word or block
// - block mode keeps voltage on whole block
// - any write in word mode programs; in block mode only a write from ram starts
// - busy while a write runs
// - word write from flash stalls cpu
// - access while ram write busy flags violation, except non-fetch reads and data writes during block wait
// - control writes need key, reads show 96h
// - fetches during flash-started op return 3fffh
// - write with program disabled flags violation
// - emergency stop aborts, clears first control
`timescale 1ns/1ns
module fews_top (
  // clock and reset
  input wire logic MCLK_I,
  input wire logic RST_N_I,
  // clock source enables (one-cycle strobes of each source)
  input wire logic ACLK_EN_I,
  input wire logic SUB_MAIN_CLOCK_EN_I,
  // control register writes
  input wire logic CTRL_WE_I,
  input wire logic [15:0] CTRL_WDATA_I,
  input wire logic CLK_WE_I,
  input wire logic [15:0] CLK_WDATA_I,
  input wire logic LOCK_WE_I,
  input wire logic [15:0] LOCK_WDATA_I,
  // cpu flash port
  input wire fews_pkg::fews_acc_t ACC_I,
  // control/status readback
  output logic [15:0] CTRL_RDATA_O,
  output logic [15:0] CLK_RDATA_O,
  output logic [15:0] STAT_RDATA_O,
  // status and system
  output logic BUSY_O,
  output logic WAIT_O,
  output logic ACCESS_VIOLATION_FLAG_O,
  output logic KEY_VIOLATION_FLAG_O,
  output logic POWER_UP_CLEAR_RESET_O,
  output logic IRQ_MASK_O,
  output logic CPU_STALL_O,
  output logic HV_ON_O,
  input wire logic ACCV_CLR_I,
  // flash read data
  output logic [15:0] RDATA_O
);
  localparam int WORDS = fews_pkg::INFO_WORDS + fews_pkg::MAIN_WORDS;

  // ===========================================
  // state
  fews_pkg::fews_state_t st_q;
  fews_pkg::fews_ctrl_t ctrl_q;
  fews_pkg::fews_clk_t clk_q;
  logic lock_q;
  logic [15:0] mem_q [WORDS];
  logic [15:0] tcnt_q;
  logic from_flash_q;
  localparam int ADDRI_W = 12;
  logic [ADDRI_W-1:0] tgt_q;
  logic [15:0] tdata_q;
  logic wipe_main_q;
  logic wipe_info_q;
  logic tick;
  logic src_en;
  logic busy;

  // ===========================================
  // address decode
  logic in_info;
  logic in_main;
  logic [ADDRI_W-1:0] idx;
  logic key_ok;
  logic key_bad;
  always_comb begin
    in_info = (ACC_I.addr >= fews_pkg::INFO_BASE) &&
              (ACC_I.addr < fews_pkg::INFO_BASE + 15'(fews_pkg::INFO_WORDS));
    in_main = (ACC_I.addr >= fews_pkg::MAIN_BASE);
    if (in_info)
      idx = ADDRI_W'(ACC_I.addr - fews_pkg::INFO_BASE);
    else
      idx = ADDRI_W'(ACC_I.addr - fews_pkg::MAIN_BASE) + ADDRI_W'(fews_pkg::INFO_WORDS);
  end
  assign key_ok = (CTRL_WE_I && CTRL_WDATA_I[15:8] == fews_pkg::KEY_WRITE) ||
                  (CLK_WE_I && CLK_WDATA_I[15:8] == fews_pkg::KEY_WRITE) ||
                  (LOCK_WE_I && LOCK_WDATA_I[15:8] == fews_pkg::KEY_WRITE);
  assign key_bad = (CTRL_WE_I && CTRL_WDATA_I[15:8] != fews_pkg::KEY_WRITE) ||
                   (CLK_WE_I && CLK_WDATA_I[15:8] != fews_pkg::KEY_WRITE) ||
                   (LOCK_WE_I && LOCK_WDATA_I[15:8] != fews_pkg::KEY_WRITE);
  assign busy = (st_q != fews_pkg::ST_IDLE);

  // ===========================================
  // timing generator clock
  always_comb begin
    unique case (clk_q.src_sel)
      fews_pkg::SRC_AUX: src_en = ACLK_EN_I;
      fews_pkg::SRC_SUB: src_en = SUB_MAIN_CLOCK_EN_I;
      default: src_en = 1'b1;
    endcase
  end
  fews_tick_div u_div (
    .clk_i(MCLK_I),
    .rst_n_i(RST_N_I),
    .run_i(busy),
    .src_en_i(src_en),
    .div_i(clk_q.ftg_divider_field),
    .tick_o(tick)
  );

  // ===========================================
  // access classification
  logic acc_in;
  logic wr_mode;
  logic start_erase;
  logic start_word;
  logic start_blk;
  logic blk_data;
  logic acc_viol;
  always_comb begin
    acc_in = ACC_I.req && (in_info || in_main);
    wr_mode = ctrl_q.program_enable;
    start_erase = 1'b0;
    start_word = 1'b0;
    start_blk = 1'b0;
    blk_data = 1'b0;
    acc_viol = 1'b0;
    if (acc_in && ACC_I.wr && st_q == fews_pkg::ST_IDLE && !lock_q) begin
      if (ctrl_q.segment_wipe || ctrl_q.mass_wipe_select) begin
        // erase starts only when the dummy write hits the selected range
        if (ctrl_q.mass_wipe_select && ctrl_q.segment_wipe)
          start_erase = 1'b1;
        else if (ctrl_q.mass_wipe_select)
          start_erase = in_main;
        else
          start_erase = 1'b1;
      end else if (wr_mode && !ctrl_q.block_program_mode) begin
        start_word = 1'b1;
      end else if (wr_mode) begin
        start_blk = ACC_I.from_ram;
      end else begin
        acc_viol = 1'b1;
      end
    end else if (acc_in && st_q == fews_pkg::ST_BLK_WAIT && ACC_I.wr) begin
      blk_data = 1'b1;
    end else if (acc_in && busy && !from_flash_q) begin
      // ram-started op: only non-fetch reads while the block waits are safe
      acc_viol = (st_q != fews_pkg::ST_BLK_WAIT) || ACC_I.fetch;
    end else if (acc_in && busy && ACC_I.wr) begin
      // flash-started op: reads and fetches see the self-jump instead
      acc_viol = 1'b1;
    end
  end

  // ===========================================
  // sequencer
  always_ff @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      st_q <= fews_pkg::ST_IDLE;
      tcnt_q <= '0;
      from_flash_q <= 1'b0;
      tgt_q <= '0;
      tdata_q <= '0;
      wipe_main_q <= 1'b0;
      wipe_info_q <= 1'b0;
    end else if (ctrl_q.emergency_stop_bit) begin
      st_q <= fews_pkg::ST_IDLE;
      tcnt_q <= '0;
    end else begin
      unique case (st_q)
        fews_pkg::ST_IDLE: begin
          tcnt_q <= '0;
          from_flash_q <= !ACC_I.from_ram;
          tgt_q <= idx;
          tdata_q <= ACC_I.wdata;
          wipe_main_q <= ctrl_q.mass_wipe_select;
          wipe_info_q <= ctrl_q.mass_wipe_select && ctrl_q.segment_wipe;
          if (start_erase)
            st_q <= fews_pkg::ST_ERASE;
          else if (start_word)
            st_q <= fews_pkg::ST_WORD;
          else if (start_blk)
            st_q <= fews_pkg::ST_BLK_PROG;
        end
        fews_pkg::ST_ERASE: begin
          // fixed length per mode, not per array size
          if (tick)
            tcnt_q <= tcnt_q + 16'h1;
          if (tick && tcnt_q == (wipe_main_q ? fews_pkg::T_MASS_ERASE
                                             : fews_pkg::T_SEG_ERASE) - 16'h1)
            st_q <= fews_pkg::ST_IDLE;
        end
        fews_pkg::ST_WORD: begin
          if (tick)
            tcnt_q <= tcnt_q + 16'h1;
          if (tick && tcnt_q == fews_pkg::T_WORD - 16'h1)
            st_q <= fews_pkg::ST_IDLE;
        end
        fews_pkg::ST_BLK_PROG: begin
          if (tick)
            tcnt_q <= tcnt_q + 16'h1;
          if (tick && tcnt_q == fews_pkg::T_BLOCK_NEXT - 16'h1) begin
            tcnt_q <= '0;
            st_q <= fews_pkg::ST_BLK_WAIT;
          end
        end
        fews_pkg::ST_BLK_WAIT: begin
          tgt_q <= idx;
          tdata_q <= ACC_I.wdata;
          if (blk_data)
            st_q <= fews_pkg::ST_BLK_PROG;
          else if (!ctrl_q.block_program_mode)
            st_q <= fews_pkg::ST_BLK_END;
        end
        fews_pkg::ST_BLK_END: begin
          if (tick)
            tcnt_q <= tcnt_q + 16'h1;
          if (tick && tcnt_q == fews_pkg::T_BLOCK_END - 16'h1)
            st_q <= fews_pkg::ST_IDLE;
        end
        default: st_q <= fews_pkg::ST_IDLE;
      endcase
    end
  end

  // ===========================================
  // flash array: programming only clears bits
  logic done_erase;
  logic done_prog;
  assign done_erase = st_q == fews_pkg::ST_ERASE && tick && tcnt_q ==
    (wipe_main_q ? fews_pkg::T_MASS_ERASE : fews_pkg::T_SEG_ERASE) - 16'h1;
  assign done_prog = (st_q == fews_pkg::ST_WORD && tick &&
                      tcnt_q == fews_pkg::T_WORD - 16'h1) ||
                     (st_q == fews_pkg::ST_BLK_PROG && tick &&
                      tcnt_q == fews_pkg::T_BLOCK_NEXT - 16'h1);
  always_ff @(posedge MCLK_I) begin
    if (done_erase) begin
      for (int i = 0; i < WORDS; i++) begin
        if (i < fews_pkg::INFO_WORDS) begin
          if (wipe_info_q || (!wipe_main_q &&
              (i >> fews_pkg::SEG_INFO_W) == (int'(tgt_q) >> fews_pkg::SEG_INFO_W)))
            mem_q[i] <= fews_pkg::ERASED_WORD;
        end else if (wipe_main_q || ((i - fews_pkg::INFO_WORDS) >> fews_pkg::SEG_MAIN_W) ==
                     ((int'(tgt_q) - fews_pkg::INFO_WORDS) >> fews_pkg::SEG_MAIN_W)) begin
          if (int'(tgt_q) >= fews_pkg::INFO_WORDS || wipe_main_q)
            mem_q[i] <= fews_pkg::ERASED_WORD;
        end
      end
    end else if (done_prog) begin
      mem_q[tgt_q] <= mem_q[tgt_q] & tdata_q;
    end
  end

  // ===========================================
  // control registers
  always_ff @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      ctrl_q <= '0;
      clk_q <= '0;
      lock_q <= 1'b1;
    end else begin
      if (ctrl_q.emergency_stop_bit)
        ctrl_q <= '0;
      else if (done_erase) begin
        ctrl_q.mass_wipe_select <= 1'b0;
        ctrl_q.segment_wipe <= 1'b0;
      end else if (CTRL_WE_I && key_ok && !busy)
        ctrl_q <= fews_pkg::fews_ctrl_t'(CTRL_WDATA_I[4:0]);
      else if (CTRL_WE_I && key_ok)
        ctrl_q.block_program_mode <= CTRL_WDATA_I[3];
      if (CLK_WE_I && key_ok && !busy)
        clk_q <= fews_pkg::fews_clk_t'(CLK_WDATA_I[7:0]);
      if (LOCK_WE_I && key_ok)
        lock_q <= LOCK_WDATA_I[0];
      if (CTRL_WE_I && key_ok && CTRL_WDATA_I[4])
        ctrl_q.emergency_stop_bit <= 1'b1;
    end
  end

  // ===========================================
  // flags and outputs
  always_ff @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      ACCESS_VIOLATION_FLAG_O <= 1'b0;
      KEY_VIOLATION_FLAG_O <= 1'b0;
      POWER_UP_CLEAR_RESET_O <= 1'b0;
    end else begin
      // set wins over clear
      if (acc_viol)
        ACCESS_VIOLATION_FLAG_O <= 1'b1;
      else if (ACCV_CLR_I)
        ACCESS_VIOLATION_FLAG_O <= 1'b0;
      if (key_bad)
        KEY_VIOLATION_FLAG_O <= 1'b1;
      POWER_UP_CLEAR_RESET_O <= key_bad;
    end
  end
  always_ff @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      BUSY_O <= 1'b0;
      WAIT_O <= 1'b0;
      IRQ_MASK_O <= 1'b0;
      CPU_STALL_O <= 1'b0;
      HV_ON_O <= 1'b0;
      RDATA_O <= '0;
      CTRL_RDATA_O <= '0;
      CLK_RDATA_O <= '0;
      STAT_RDATA_O <= '0;
    end else begin
      BUSY_O <= busy;
      WAIT_O <= st_q == fews_pkg::ST_BLK_WAIT;
      IRQ_MASK_O <= busy;
      CPU_STALL_O <= busy && from_flash_q;
      // block mode keeps the pump up between words
      HV_ON_O <= (st_q == fews_pkg::ST_WORD && tcnt_q < fews_pkg::T_WORD_HV) ||
                 st_q == fews_pkg::ST_BLK_PROG || st_q == fews_pkg::ST_BLK_WAIT ||
                 st_q == fews_pkg::ST_ERASE;
      if (busy && (st_q != fews_pkg::ST_BLK_WAIT || ACC_I.fetch))
        RDATA_O <= fews_pkg::SELF_JUMP;
      else if (in_info || in_main)
        RDATA_O <= mem_q[idx];
      else
        RDATA_O <= '0;
      CTRL_RDATA_O <= {fews_pkg::KEY_READ, 3'h0, ctrl_q};
      CLK_RDATA_O <= {fews_pkg::KEY_READ, clk_q};
      STAT_RDATA_O <= {fews_pkg::KEY_READ, 4'h0, WAIT_O, lock_q,
                       ACCESS_VIOLATION_FLAG_O, busy};
    end
  end
endmodule

// File: fews_props.sv
// checker: port-level properties of the flash erase/write sequencer
`timescale 1ns/1ns
module fews_props (
  // clock and reset
  input wire logic MCLK_I,
  input wire logic RST_N_I,
  // inputs watched
  input wire logic CTRL_WE_I,
  input wire logic [15:0] CTRL_WDATA_I,
  input wire logic ACCV_CLR_I,
  input wire fews_pkg::fews_acc_t ACC_I,
  // outputs watched
  input wire logic [15:0] CTRL_RDATA_O,
  input wire logic [15:0] STAT_RDATA_O,
  input wire logic BUSY_O,
  input wire logic WAIT_O,
  input wire logic ACCESS_VIOLATION_FLAG_O,
  input wire logic KEY_VIOLATION_FLAG_O,
  input wire logic POWER_UP_CLEAR_RESET_O,
  input wire logic IRQ_MASK_O,
  input wire logic CPU_STALL_O,
  input wire logic HV_ON_O,
  input wire logic [15:0] RDATA_O
);
  default clocking @(posedge MCLK_I); endclocking
  default disable iff (!RST_N_I);
  // ===========================================
  // sequences
  sequence s_word_start;
    !BUSY_O && !STAT_RDATA_O[2] && CTRL_RDATA_O[4:0] == 5'h04 && ACC_I.req && ACC_I.wr
      && ACC_I.addr >= fews_pkg::MAIN_BASE;
  endsequence
  sequence s_prog_on;
    BUSY_O && HV_ON_O && IRQ_MASK_O;
  endsequence
  // ===========================================
  // properties
  a_word_busy_hv: assert property (s_word_start |=> ##1 s_prog_on)
    else $error("word write did not raise busy and voltage");
  a_lock_no_start: assert property (STAT_RDATA_O[2] && !BUSY_O && ACC_I.req && ACC_I.wr
    |=> !BUSY_O [*2]) else $error("locked write started a cycle");
  a_wr_dis_accv: assert property (!BUSY_O && CTRL_RDATA_O[2:0] == 3'h0 && ACC_I.req
    && ACC_I.wr && !ACCV_CLR_I |=> ACCESS_VIOLATION_FLAG_O && !BUSY_O)
    else $error("disabled write not flagged");
  a_busy_accv: assert property (BUSY_O && !WAIT_O && ACC_I.req && ACC_I.from_ram
    && ACC_I.addr >= fews_pkg::MAIN_BASE && !ACCV_CLR_I
    |=> ACCESS_VIOLATION_FLAG_O) else $error("busy access not flagged");
  a_self_jump: assert property (BUSY_O && ACC_I.req && ACC_I.fetch && !ACC_I.from_ram
    |=> RDATA_O == fews_pkg::SELF_JUMP) else $error("fetch during op not self jump");
  a_key_bad: assert property (CTRL_WE_I && CTRL_WDATA_I[15:8] != fews_pkg::KEY_WRITE
    |=> KEY_VIOLATION_FLAG_O && POWER_UP_CLEAR_RESET_O) else $error("bad key not flagged");
  a_irq_masked: assert property (BUSY_O |-> IRQ_MASK_O) else $error("irq open while busy");
  a_stall_busy: assert property (CPU_STALL_O |-> BUSY_O) else $error("stall without busy");
  a_hv_busy: assert property (HV_ON_O |-> BUSY_O) else $error("voltage on while idle");
  a_accv_sticky: assert property (ACCESS_VIOLATION_FLAG_O && !ACCV_CLR_I
    |=> ACCESS_VIOLATION_FLAG_O) else $error("violation flag dropped");
endmodule

// File: fews_cpu_model.sv
// model: cpu core issuing flash reads, writes and fetches
`timescale 1ns/1ns
module fews_cpu_model (
  // clock
  input wire logic clk_i,
  // flash port
  output fews_pkg::fews_acc_t acc_o
);
  initial acc_o = '0;
  // one access per call; released fields show inverted junk, not stale data
  task automatic access(input logic w, f, r, input logic [14:0] a, input logic [15:0] d);
    acc_o = '{req: 1'b1, wr: w, fetch: f, from_ram: r, addr: a, wdata: d};
    @(posedge clk_i);
    #1;
    acc_o = '{req: 1'b0, wr: ~w, fetch: ~f, from_ram: ~r, addr: ~a, wdata: ~d};
  endtask
endmodule

// File: fews_tb_top.sv
// testbench: directed sequences for the flash erase/write sequencer
`timescale 1ns/1ns
module fews_tb_top;
  logic clk, rst_n, aen, sen, cwe, kwe, lwe, aclr;
  logic [15:0] cwd, kwd, lwd, crd, krd, srd, rd;
  logic busy, wt, accv, key_violation_flag, power_up_clear_reset, irqm, stall, hv;
  fews_pkg::fews_acc_t acc;
  int n_mismatch = 0, n_compared = 0, ph = 0, n;
  logic [15:0] e;
  logic [7:0] cfg [3] = '{8'h80, 8'h40, 8'h01};
  int per [3] = '{1, 3, 4};
  logic [15:0] dat [3] = '{16'h0123, 16'hff0f, 16'h0f00};
  fews_cpu_model cpu (.clk_i(clk), .acc_o(acc));
  fews_top dut (.MCLK_I(clk), .RST_N_I(rst_n), .ACLK_EN_I(aen), .SUB_MAIN_CLOCK_EN_I(sen),
    .CTRL_WE_I(cwe), .CTRL_WDATA_I(cwd), .CLK_WE_I(kwe), .CLK_WDATA_I(kwd),
    .LOCK_WE_I(lwe), .LOCK_WDATA_I(lwd), .ACC_I(acc), .CTRL_RDATA_O(crd),
    .CLK_RDATA_O(krd), .STAT_RDATA_O(srd), .BUSY_O(busy), .WAIT_O(wt),
    .ACCESS_VIOLATION_FLAG_O(accv), .KEY_VIOLATION_FLAG_O(key_violation_flag),
    .POWER_UP_CLEAR_RESET_O(power_up_clear_reset), .IRQ_MASK_O(irqm), .CPU_STALL_O(stall),
    .HV_ON_O(hv), .ACCV_CLR_I(aclr), .RDATA_O(rd));
  // ===========================================
  // clock and source strobes
  initial begin
    clk = 0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    #1;
    ph = ph + 1;
    aen = (ph % 2 == 0);
    sen = (ph % 3 == 0);
  end
  // ===========================================
  // tasks
  task automatic chk(input string nm, input logic [15:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // extra edge so registered readback settles before the next access
  task automatic reg_wr(input int sel, input logic [15:0] d);
    cwd = d;
    kwd = d;
    lwd = d;
    cwe = (sel == 0);
    kwe = (sel == 1);
    lwe = (sel == 2);
    @(posedge clk);
    #1;
    cwe = 0;
    kwe = 0;
    lwe = 0;
    @(posedge clk);
    #1;
  endtask
  // busy shows one edge after the start, so look from the next edge on
  task automatic run_len();
    @(posedge clk);
    #1;
    n = 0;
    while (busy === 1'b1 && n < 20000) begin
      @(posedge clk);
      #1;
      n++;
    end
  endtask
  task automatic wait_wt();
    @(posedge clk);
    #1;
    n = 0;
    while (wt !== 1'b1 && n < 100) begin
      @(posedge clk);
      #1;
      n++;
    end
  endtask
  // trailing edge keeps back-to-back reads from re-driving in one step
  task automatic rd_chk(input string nm, input logic [14:0] a, input logic [15:0] x);
    cpu.access(0, 0, 1, a, 16'h0);
    chk(nm, rd, x);
    @(posedge clk);
    #1;
  endtask
  task automatic print_verdict();
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // ===========================================
  // watchdog, well past the two long erases
  initial begin
    #400000;
    n_mismatch++;
    print_verdict();
  end
  // ===========================================
  // main sequence
  initial begin
    {rst_n, aen, sen, cwe, kwe, lwe, aclr} = '0;
    {cwd, kwd, lwd} = '0;
    repeat (2) @(posedge clk);
    #1 rst_n = 1;
    // readback is registered: give it one edge after reset
    @(posedge clk);
    #1;
    chk("lock", srd[2], 1'b1);
    reg_wr(1, 16'ha580);
    chk("clk_rd", krd, 16'h9680);
    reg_wr(0, 16'ha504);
    chk("rd_key", crd[15:8], 8'h96);
    cpu.access(1, 0, 1, 15'h7800, 16'h0);
    @(posedge clk);
    #1;
    chk("locked", busy, 1'b0);
    reg_wr(2, 16'ha500);
    reg_wr(0, 16'ha503);
    cpu.access(1, 0, 1, 15'h0800, 16'h0);
    run_len();
    chk("all_len", (n >= 5297 && n <= 5300), 1'b1);
    chk("modes", crd[1:0], 2'h0);
    rd_chk("erased_main", 15'h7abc, 16'hffff);
    rd_chk("erased_info", 15'h0840, 16'hffff);
    reg_wr(0, 16'ha504);
    e = 16'hffff;
    for (int i = 0; i < 3; i++) begin
      reg_wr(1, {8'ha5, cfg[i]});
      cpu.access(1, 0, 1, 15'h7800, dat[i]);
      @(posedge clk);
      #1;
      chk("hv", hv, 1'b1);
      chk("irq", irqm, 1'b1);
      run_len();
      chk("word_len", (n >= 35 * per[i] - per[i] && n <= 35 * per[i] + per[i] + 3), 1);
      chk("irq_off", irqm, 1'b0);
      e = e & dat[i];
      rd_chk("word_and", 15'h7800, e);
    end
    reg_wr(1, 16'ha580);
    cpu.access(1, 0, 1, 15'h7810, 16'haaaa);
    @(posedge clk);
    #1;
    cpu.access(0, 0, 1, 15'h7811, 16'h0);
    chk("ram_accv", accv, 1'b1);
    run_len();
    aclr = 1;
    @(posedge clk);
    #1 aclr = 0;
    chk("accv_clr", accv, 1'b0);
    cpu.access(1, 0, 0, 15'h7900, 16'h5555);
    @(posedge clk);
    #1;
    chk("stall", stall, 1'b1);
    cpu.access(0, 1, 0, 15'h7901, 16'h0);
    chk("self_jump", rd, 16'h3fff);
    run_len();
    chk("unstall", stall, 1'b0);
    reg_wr(0, 16'ha500);
    cpu.access(1, 0, 1, 15'h7800, 16'h0);
    chk("wr_dis", accv, 1'b1);
    rd_chk("untouched", 15'h7800, e);
    aclr = 1;
    @(posedge clk);
    #1 aclr = 0;
    reg_wr(0, 16'ha501);
    cpu.access(1, 0, 1, 15'h0100, 16'h0);
    @(posedge clk);
    #1;
    chk("stray_busy", busy, 1'b0);
    chk("stray_flag", accv, 1'b0);
    cpu.access(1, 0, 1, 15'h7820, 16'h0);
    run_len();
    chk("seg_len", (n >= 4819 && n <= 4822), 1'b1);
    rd_chk("seg_gone", 15'h7800, 16'hffff);
    rd_chk("seg_keep", 15'h7900, 16'h5555);
    // block write from ram: two words, then clear the block bit
    reg_wr(0, 16'ha50c);
    cpu.access(1, 0, 1, 15'h7830, 16'h1234);
    wait_wt();
    chk("blk_wait", wt, 1'b1);
    chk("blk_hv", hv, 1'b1);
    cpu.access(1, 0, 1, 15'h7831, 16'h5678);
    wait_wt();
    chk("blk_wait2", wt, 1'b1);
    reg_wr(0, 16'ha504);
    run_len();
    chk("blk_end", (n >= 6 && n <= 8), 1'b1);
    rd_chk("blk_w0", 15'h7830, 16'h1234);
    rd_chk("blk_w1", 15'h7831, 16'h5678);
    reg_wr(0, 16'ha504);
    cpu.access(1, 0, 1, 15'h7a00, 16'h0);
    reg_wr(0, 16'ha510);
    // the stop lands one edge after the write, busy one edge later
    @(posedge clk);
    #1;
    chk("stop_busy", busy, 1'b0);
    chk("stop_ctrl", crd[7:0], 8'h00);
    reg_wr(0, 16'h1204);
    chk("key_flag", key_violation_flag, 1'b1);
    print_verdict();
  end
endmodule
bind fews_top fews_props u_props (.*);
